// >>> core/hsr_readout.sv
// module: serial slave and measurement sequencer of the humidity sensor
`timescale 1ns/10ps
`default_nettype none
module hsr_readout
    import hsr_pkg::*;
#(
    parameter int CONV_CYCLES = HSR_CONV_CYCLES,
    parameter int CORR_CYCLES = HSR_CORR_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [13:0] adc_humidity,
    input  wire logic [13:0] adc_temperature,
    output logic             meas_busy,
    output logic             awake
);
    // refuse counts that the sequencer timer cannot serve
    if (CONV_CYCLES < 1 || CORR_CYCLES < 1) begin : g_bad_counts
        $error("conversion counts must be at least one");
    end

    localparam int CW = $clog2(CONV_CYCLES + CORR_CYCLES + 1);

    // ------------------------------------------------------------------
    // line synchronisers
    // ------------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;

    // two stages per line; only the second stage feeds any logic
    // reset to the idle high level so no false edge follows reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    // edges show three clocks after the pin moves; each line phase must
    // last longer than that so driven data settles before the next rise
    // no lower clock rate limit: edges are found by sampling, any slow rate works
    assign scl_rise   = scl_sync[1] & ~scl_prev;
    assign scl_fall   = ~scl_sync[1] & scl_prev;
    // data moving while clock is high marks start or stop
    assign start_seen = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    assign stop_seen  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

    // slave only: the clock line is never driven
    // no clock stretching, so the master alone sets the bit rate
    assign scl_out = 1'b0;
    assign scl_oe  = 1'b0;
    assign sda_out = 1'b0;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    hsr_bus_state_t bus_state;
    logic [7:0]     shreg;
    logic [3:0]     bit_cnt;
    logic [1:0]     byte_idx;
    logic           is_read;
    logic           meas_req;     // one-cycle pulse toward the sequencer
    logic           fetch_done;   // one-cycle pulse: read reached data
    logic           drive_low;
    logic [31:0]    result_word;
    logic [1:0]     status;
    hsr_sample_t    sample;
    logic [7:0]     next_byte;    // byte loaded after a master ack

    // status on top of humidity, then temperature, msb first, 2 pad bits
    assign result_word = {status, sample.humidity,
                          sample.temperature, 2'h0};

    function automatic logic [7:0] result_byte(input logic [31:0] w,
                                               input logic [1:0]  idx);
        result_byte = w[8'(31 - 8 * idx) -: 8];
    endfunction : result_byte

    // index wraps past byte four, so byte one follows byte four again
    assign next_byte = result_byte(result_word, byte_idx);

    // byte framing and acknowledge handling
    // start and stop win over every state, so a cut frame always ends
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bus_state  <= HSR_BUS_IDLE;
            shreg      <= 8'h00;
            bit_cnt    <= 4'h0;
            byte_idx   <= 2'h0;
            is_read    <= 1'b0;
            drive_low  <= 1'b0;
            meas_req   <= 1'b0;
            fetch_done <= 1'b0;
        end else begin
            meas_req   <= 1'b0;
            fetch_done <= 1'b0;
            if (start_seen) begin
                bus_state <= HSR_BUS_ADDR;
                bit_cnt   <= 4'h0;
                drive_low <= 1'b0;
            end else if (stop_seen) begin
                bus_state <= HSR_BUS_IDLE;
                drive_low <= 1'b0;
            end else begin
                case (bus_state)
                    HSR_BUS_IDLE: begin
                        drive_low <= 1'b0;
                    end
                    HSR_BUS_ADDR: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (shreg[7:1] == HSR_SLAVE_ADDR) begin
                                drive_low <= 1'b1;
                                is_read   <= shreg[0];
                                bus_state <= HSR_BUS_AACK;
                            end else begin
                                bus_state <= HSR_BUS_IDLE;
                            end
                        end
                    end
                    HSR_BUS_AACK: begin
                        if (scl_fall) begin                  // ack bit done
                            bit_cnt  <= 4'h0;
                            byte_idx <= 2'h0;
                            if (is_read) begin
                                shreg      <= result_byte(result_word, 2'h0);
                                drive_low  <= ~result_word[31];
                                fetch_done <= 1'b1;
                                bus_state  <= HSR_BUS_RD;
                            end else begin
                                drive_low <= 1'b0;
                                meas_req  <= 1'b1;
                                bus_state <= HSR_BUS_WR;
                            end
                        end
                    end
                    HSR_BUS_WR: begin
                        // written bytes are acked and thrown away
                        // the request fired already at the address ack
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                drive_low <= 1'b1;
                            end else if (bit_cnt == 4'h9) begin
                                drive_low <= 1'b0;
                                bit_cnt   <= 4'h0;
                            end
                        end
                    end
                    HSR_BUS_RD: begin
                        // shift out on falling edges, msb first
                        // each bit leaves three clocks after the line falls
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == 4'h8) begin
                                drive_low <= 1'b0;           // release for ack
                                bus_state <= HSR_BUS_MACK;
                            end else begin
                                shreg     <= {shreg[6:0], 1'b0};
                                drive_low <= ~shreg[6];
                            end
                        end
                    end
                    HSR_BUS_MACK: begin
                        if (scl_rise) begin
                            if (sda_sync[1]) begin           // nack
                                bus_state <= HSR_BUS_IDLE;
                            end else begin                   // ack: next byte
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end else if (scl_fall) begin
                            // load the byte chosen at the ack, msb out first
                            bit_cnt   <= 4'h0;
                            shreg     <= next_byte;
                            drive_low <= ~next_byte[7];
                            bus_state <= HSR_BUS_RD;
                        end
                    end
                    default: begin
                        bus_state <= HSR_BUS_IDLE;
                    end
                endcase
            end
        end
    end

    // pull the data line only; open-drain, never push high
    assign sda_oe = drive_low;

    // ------------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------------
    hsr_meas_state_t meas_state;
    logic [CW-1:0]   tmr;
    logic [13:0]     hum_raw;
    logic [13:0]     tmp_raw;
    logic            result_update;

    // sleeps until a request; one cycle runs humidity, temperature, correction
    // the timer loads on entry to each phase and counts down to zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meas_state    <= HSR_M_SLEEP;
            tmr           <= '0;
            hum_raw       <= 14'h0000;
            tmp_raw       <= 14'h0000;
            result_update <= 1'b0;
        end else begin
            result_update <= 1'b0;
            case (meas_state)
                HSR_M_SLEEP: begin
                    if (meas_req) begin
                        meas_state <= HSR_M_HUM;
                        tmr        <= CW'(CONV_CYCLES - 1);
                    end
                end
                HSR_M_HUM: begin
                    if (tmr == '0) begin
                        hum_raw    <= adc_humidity;
                        meas_state <= HSR_M_TEMP;
                        tmr        <= CW'(CONV_CYCLES - 1);
                    end else begin
                        tmr <= tmr - CW'(1);
                    end
                end
                HSR_M_TEMP: begin
                    if (tmr == '0) begin
                        tmp_raw    <= adc_temperature;
                        meas_state <= HSR_M_CORR;
                        tmr        <= CW'(CORR_CYCLES - 1);
                    end else begin
                        tmr <= tmr - CW'(1);
                    end
                end
                HSR_M_CORR: begin
                    if (tmr == '0) begin
                        result_update <= 1'b1;
                        meas_state    <= HSR_M_SLEEP;
                    end else begin
                        tmr <= tmr - CW'(1);
                    end
                end
                default: begin
                    meas_state <= HSR_M_SLEEP;
                end
            endcase
        end
    end

    // output register, written once at the end of correction; raw values
    // wait in holding registers so humidity and temperature change in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sample <= '0;
        end else if (result_update) begin
            sample.humidity    <= hum_raw;
            sample.temperature <= tmp_raw;
        end
    end

    // freshness: stale from reset, fresh on update, stale once fetched;
    // a fetch that collides with an update leaves the new data fresh
    // byte one is loaded at the same edge, so it still shows the old code
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status <= HSR_STAT_STALE;
        end else if (result_update) begin
            status <= HSR_STAT_FRESH;
        end else if (fetch_done) begin
            status <= HSR_STAT_STALE;
        end
    end

    // busy is decoded straight from the state register, no added delay
    // awake also covers a bus transaction, the view a power switch needs
    assign meas_busy = (meas_state != HSR_M_SLEEP);
    assign awake     = meas_busy | (bus_state != HSR_BUS_IDLE);
endmodule : hsr_readout
`default_nettype wire

// >>> inc/hsr_pkg.sv
// package: constants and types for the humidity sensor serial readout
// What this block does
// - act only as bus slave; work at 100 kHz and 400 kHz bit rates
// - no lower limit on serial clock rate; 20 kHz is for test only
// - acknowledge only seven-bit address 0x44; ignore every other address
// - sample data on rising clock edge; driver holds data while clock high
// - direction bit after address: 1 reads sensor, 0 writes to sensor
// - each unit is eight bits then a response bit: 0 ack, 1 nack
// - sleep after reset; convert only on a measurement request
// - address with direction 0 wakes device and starts one measurement
// - humidity conversion, temperature conversion, correction, then update
// - results scaled to fourteen bits, sent most significant byte first
// - address with direction 1 is acked and result bytes follow
// - send bytes until master nacks; stopping after byte two is allowed
// - bytes one and two hold two status bits on top, then fourteen humidity bits
// - bytes three and four hold temperature on top; low two bits undefined
// - status 00 for unfetched results, 01 once already fetched
// - fetch before or during first measurement reports stale status
// - each conversion takes about 16.90 ms; correction adds 16 clock cycles
// - full result is four bytes; humidity bits 29..16, temperature 15..2
package hsr_pkg;
    // ------------------------------------------------------------------
    // bus constants
    // ------------------------------------------------------------------
    localparam logic [6:0] HSR_SLAVE_ADDR   = 7'h44;
    localparam logic [1:0] HSR_STAT_FRESH   = 2'h0;
    localparam logic [1:0] HSR_STAT_STALE   = 2'h1;
    localparam int         HSR_RESULT_BYTES = 4;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int HSR_CLK_HZ        = 40_000_000;
    localparam int HSR_CONV_TIME_US  = 16_900;   // 16.90 ms per conversion
    localparam int HSR_CORR_CYCLES   = 16;       // correction phase length
    localparam int HSR_CONV_CYCLES   =
        (HSR_CONV_TIME_US / 1000) * (HSR_CLK_HZ / 1000)
        + ((HSR_CONV_TIME_US % 1000) * (HSR_CLK_HZ / 1000)) / 1000;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [13:0] humidity;
        logic [13:0] temperature;
    } hsr_sample_t;

    typedef struct packed {
        logic in;   // synchronised line level
        logic out;  // level driven when enabled (always 0)
        logic oe;   // high while this block pulls the line low
    } hsr_pin_t;

    typedef enum logic [5:0] {
        HSR_BUS_IDLE = 6'h01,
        HSR_BUS_ADDR = 6'h02,
        HSR_BUS_AACK = 6'h04,
        HSR_BUS_WR   = 6'h08,
        HSR_BUS_RD   = 6'h10,
        HSR_BUS_MACK = 6'h20
    } hsr_bus_state_t;

    typedef enum logic [3:0] {
        HSR_M_SLEEP = 4'h1,
        HSR_M_HUM   = 4'h2,
        HSR_M_TEMP  = 4'h4,
        HSR_M_CORR  = 4'h8
    } hsr_meas_state_t;
endpackage : hsr_pkg

// >>> dv/hsr_master.sv
// serial bus master model facing the sensor readout
`timescale 1ns/10ps
`default_nettype none
module hsr_master (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // ------------------------------------------
    // lines released at time zero
    // ------------------------------------------
    // the bench calls this once at time zero; one process owns the lines
    task automatic idle();
        scl      <= 1'b1;
        sda_pull <= 1'b0;
    endtask : idle
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // data falls while clock is high, then clock drops
    task automatic start();
        sda_pull <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask : start
    // data rises while clock is high; bus free time after
    task automatic stop();
        tick(2);
        sda_pull <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_pull <= 1'b0;
        tick(40);
    endtask : stop
    // data set mid-low, held over the high phase, sampled there
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_pull <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl <= 1'b0;
    endtask : bit_io
    // eight bits msb first then the response bit
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(mack, ack);
    endtask : xfer
endmodule : hsr_master
`default_nettype wire

// >>> dv/hsr_readout_monitor.sv
// assertion checker for the humidity sensor serial readout
`timescale 1ns/10ps
`default_nettype none
module hsr_readout_monitor
    import hsr_pkg::*;
#(
    parameter int CONV_CYCLES = HSR_CONV_CYCLES,
    parameter int CORR_CYCLES = HSR_CORR_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic meas_busy,
    input wire logic awake
);
    localparam int MEAS_LEN = 2 * CONV_CYCLES + CORR_CYCLES;
    int         busy_cnt;
    logic [4:0] oe_age;
    // ------------------------------------------
    // helper counters
    // ------------------------------------------
    // length of the current busy stretch, cleared when idle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) busy_cnt <= 0;
        else if (meas_busy) busy_cnt <= busy_cnt + 1;
        else busy_cnt <= 0;
    end
    // cycles since data line was last pulled, saturating
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) oe_age <= 5'h1f;
        else if (sda_oe) oe_age <= 5'h0;
        else if (oe_age != 5'h1f) oe_age <= oe_age + 5'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    clock_free_a: assert property (!scl_oe && !scl_out)
        else $error("serial clock line driven");
    sda_level_a: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    busy_awake_a: assert property (meas_busy |-> awake)
        else $error("measuring while asleep");
    idle_quiet_a: assert property (!awake |-> !sda_oe && !meas_busy)
        else $error("activity while asleep");
    busy_len_a: assert property (
        $fell(meas_busy) |-> busy_cnt == MEAS_LEN)
        else $error("measurement length wrong");
    busy_hold_a: assert property (
        $rose(meas_busy) |=> meas_busy [*8])
        else $error("measurement cut short");
    busy_cause_a: assert property (
        $rose(meas_busy) |-> oe_age < 5'h10)
        else $error("measurement without address ack");
    oe_stable_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed while clock high");
endmodule : hsr_readout_monitor
bind hsr_readout hsr_readout_monitor #(
    .CONV_CYCLES(CONV_CYCLES),
    .CORR_CYCLES(CORR_CYCLES)
) u_hsr_readout_monitor (
    .mclk(mclk),
    .nrst(nrst),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .meas_busy(meas_busy),
    .awake(awake)
);
`default_nettype wire

// >>> dv/hsr_readout_bench.sv
// self-checking bench of the humidity sensor serial readout
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module hsr_readout_bench
    import hsr_pkg::*;
;
    localparam int CONV = 50;
    localparam int CORR = 16;
    logic mclk, nrst, sda_line, scl_line, scl_m, sda_pull, ack;
    logic scl_out, scl_oe, sda_out, sda_oe, meas_busy, awake;
    logic [13:0] adc_h, adc_t;
    int fails, checks, seed;
    // ------------------------------------------
    // clock, open-drain lines with pull-ups
    // ------------------------------------------
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    assign sda_line = !(sda_oe || sda_pull);
    assign scl_line = scl_m && !scl_oe;
    hsr_readout #(.CONV_CYCLES(CONV), .CORR_CYCLES(CORR)) u_hsr_readout (
        .mclk(mclk), .nrst(nrst), .scl_in(scl_line), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .adc_humidity(adc_h), .adc_temperature(adc_t),
        .meas_busy(meas_busy), .awake(awake));
    hsr_master u_hsr_master (
        .mclk(mclk), .sda(sda_line), .scl(scl_m), .sda_pull(sda_pull));
    // expected byte i of a fetch: status, humidity, temperature
    function automatic logic [7:0] exp_byte(input logic [1:0] st,
                                            input int i);
        logic [31:0] w;
        w = {st, adc_h, adc_t, 2'h0};
        return w[31 - 8 * i -: 8];
    endfunction : exp_byte
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // read n bytes; with full set, low two bits of byte four are masked off, else only byte one's status bits compared
    task automatic fetch(input int n, input logic [1:0] st,
                         input logic full);
        logic [7:0] q, m;
        u_hsr_master.start();
        u_hsr_master.xfer({HSR_SLAVE_ADDR, 1'b1}, 1'b1, q, ack);
        `CHK("read ack", 1'b0, ack)
        for (int i = 0; i < n; i++) begin
            u_hsr_master.xfer(8'hff, i == n - 1, q, ack);
            m = full ? ((i == 3) ? 8'hfc : 8'hff) : ((i == 0) ? 8'hc0 : 8'h0);
            `CHK("byte", exp_byte(st, i) & m, q & m)
        end
        u_hsr_master.stop();
    endtask : fetch
    // write address, then one ignored data byte when acked
    task automatic trigger(input logic [6:0] a);
        logic [7:0] q;
        u_hsr_master.start();
        u_hsr_master.xfer({a, 1'b0}, 1'b1, q, ack);
        u_hsr_master.tick(6); // request needs about four clocks to land
        if (a == HSR_SLAVE_ADDR) `CHK("busy start", 1'b1, meas_busy)
        if (ack === 1'b0) u_hsr_master.xfer(8'($urandom), 1'b1, q, ack);
        u_hsr_master.stop();
    endtask : trigger
    // watchdog well beyond the expected run of about 4k cycles
    initial begin
        #2_000_000;
        fails++;
        finish_test();
    end
    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial begin
        fails = 0;
        checks = 0;
        u_hsr_master.idle();
        nrst = 1'b0;
        adc_h = 14'h0;
        adc_t = 14'h0;
        seed = $urandom(32'hed9f);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("sleep", 1'b0, meas_busy || awake)
        fetch(4, 2'h1, 1'b0);
        $display("test power-on fetch done");
        trigger(7'h44 ^ 7'($urandom_range(1, 127)));
        `CHK("foreign ack", 1'b1, ack)
        `CHK("busy", 1'b0, meas_busy)
        $display("test foreign address done");
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            adc_h <= (k == 1) ? 14'h3fff : 14'($urandom);
            adc_t <= (k == 2) ? 14'h0 : 14'($urandom);
            trigger(HSR_SLAVE_ADDR);
            `CHK("data ack", 1'b0, ack)
            for (int n = 0; n < 400 && meas_busy === 1'b1; n++) begin
                @(posedge mclk);
            end
            `CHK("busy end", 1'b0, meas_busy)
            fetch(4, 2'h0, 1'b1);
            fetch(2, 2'h1, 1'b1);
            $display("test measure %0d done", k);
        end
        finish_test();
    end
endmodule : hsr_readout_bench
`default_nettype wire
